// [design/dac_pkg.sv]
// dac_pkg: register map, field layout, reset values and widths for the
// two-channel converter controller.
// assumes a plain byte-addressed register port with 32-bit data.
package dac_pkg;

  // register byte addresses
  localparam logic [31:0] DAC_MODE_ADDR   = 32'h4003c004;
  localparam logic [31:0] DAC_CHEN_ADDR   = 32'h4003c010;
  localparam logic [31:0] DAC_CHDIS_ADDR  = 32'h4003c014;
  localparam logic [31:0] DAC_CHSTAT_ADDR = 32'h4003c018;
  localparam logic [31:0] DAC_DATA_ADDR   = 32'h4003c020;
  localparam logic [31:0] DAC_IEN_ADDR    = 32'h4003c024;
  localparam logic [31:0] DAC_IDIS_ADDR   = 32'h4003c028;
  localparam logic [31:0] DAC_IMASK_ADDR  = 32'h4003c02c;
  localparam logic [31:0] DAC_ISTAT_ADDR  = 32'h4003c030;
  localparam logic [31:0] DAC_ACUR_ADDR   = 32'h4003c094;
  localparam logic [31:0] DAC_WPMODE_ADDR = 32'h4003c0e4;
  localparam logic [31:0] DAC_WPSTAT_ADDR = 32'h4003c0e8;
  localparam logic [31:0] DAC_TCNT_ADDR   = 32'h4003c108;
  localparam logic [31:0] DAC_TNCNT_ADDR  = 32'h4003c118;

  // field positions
  localparam int DAC_MODE_WORD_BIT = 4;
  localparam int DAC_MODE_SEL_LSB  = 16;
  localparam int DAC_IRQ_TRANSMIT_READY_FLAG     = 0;
  localparam int DAC_IRQ_EOC       = 1;
  localparam int DAC_IRQ_TRANSFER_END_FLAG     = 2;
  localparam int DAC_IRQ_BUFFER_EMPTY_FLAG    = 3;
  localparam int DAC_ACUR_CORE_LSB = 8;
  localparam int DAC_WP_KEY_LSB    = 8;
  localparam int DAC_WP_ADDR_LSB   = 8;

  // widths
  localparam int DAC_NIRQ    = 4;
  localparam int DAC_CNT_W   = 16;
  localparam int DAC_SMP_W   = 16;

  // key and reset values
  localparam logic [23:0]          DAC_WP_KEY     = 24'h444143;
  localparam logic [DAC_NIRQ-1:0]  DAC_IMASK_RST  = 4'h0;
  localparam logic [1:0]           DAC_CHEN_RST   = 2'h0;
  localparam logic [3:0]           DAC_OUTCUR_RST = 4'h0;
  localparam logic [1:0]           DAC_BIAS_RST   = 2'h0;
  localparam logic [DAC_CNT_W-1:0] DAC_CNT_RST    = 16'h0000;

endpackage

// [design/dac_seq_if.sv]
// dac_seq_if: carries sample words from the register block to the
// sample sequencer, and the sequencer's samples toward the core.
// assumes one clock shared by both ends.
`timescale 1ns/1ns
interface dac_seq_if;
  import dac_pkg::*;
  logic                 push;
  logic [31:0]          wdata;
  logic                 word;
  logic                 chan;
  logic                 core_ready;
  logic                 ready;
  logic                 smp_valid;
  logic [DAC_SMP_W-1:0] smp_data;
  logic                 smp_chan;

  modport regs (output push, wdata, word, chan, core_ready,
                input  ready, smp_valid, smp_data, smp_chan);
  modport seq  (input  push, wdata, word, chan, core_ready,
                output ready, smp_valid, smp_data, smp_chan);
endinterface

// [design/dac_seq.sv]
// dac_seq: holds one written data word and hands its samples to the
// converter core one at a time, low half first.
// assumes the core takes a sample in any cycle it shows ready.
`timescale 1ns/1ns
module dac_seq
  import dac_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // link to the register block
  dac_seq_if.seq    sif
);

  logic [DAC_SMP_W-1:0] hi_q;
  logic [DAC_SMP_W-1:0] cur_q;
  logic [1:0]           left_q;
  logic                 chan_q;
  logic                 vld_q;
  logic [DAC_SMP_W-1:0] dat_q;
  logic                 emit;

  // a sample leaves whenever something is held and the core can take it
  assign emit      = (left_q != 2'h0) && sif.core_ready;
  assign sif.ready = (left_q == 2'h0);
  assign sif.smp_valid = vld_q;
  assign sif.smp_data  = dat_q;
  assign sif.smp_chan  = chan_q;

  // holding store; a push while busy is never made by the register block
  always_ff @(posedge clk) begin
    if (srst) begin
      left_q <= 2'h0;
      hi_q   <= '0;
      cur_q  <= '0;
      chan_q <= 1'b0;
      vld_q  <= 1'b0;
      dat_q  <= '0;
    end else begin
      vld_q <= emit;
      if (sif.push) begin
        left_q <= sif.word ? 2'h2 : 2'h1;
        cur_q  <= sif.wdata[15:0];
        hi_q   <= sif.wdata[31:16];
        chan_q <= sif.chan;
      end else if (emit) begin
        // the sample leaves with its valid pulse; the upper half moves up
        left_q <= left_q - 2'h1;
        dat_q  <= cur_q;
        cur_q  <= hi_q;
      end
    end
  end

endmodule // dac_seq

// [design/dac_ctrl_regs.sv]
// dac_ctrl_regs: register block of a two-channel converter controller:
// channel state, data word, interrupt mask and flags, analog current
// control, key-guarded write protection and violation capture.
// assumes the register master never strobes read and write together,
// and that the core and transfer-counter logic share this clock.
//
// Behaviour
// - channel status bits 0 and 1 read one for each enabled channel
// - half-word mode uses data bits 15:0, word mode uses all 32 bits
// - a word-mode data write delivers two samples, one per half-word
// - interrupt enable register sets bits: ready 0, eoc 1, transfer_end_flag 2, bufe 3
// - interrupt disable register clears the same four bits, same positions
// - interrupt mask register reads which of the four sources are enabled
// - transmit ready flag reads one while a new data word can be taken
// - end-of-conversion flag sets on a conversion, clears on status read
// - transfer end flag sets when counter hits zero, cleared by counter writes
// - buffer empty flag follows the same set and clear as transfer end
// - analog current register holds per-channel output current fields
// - analog current register holds the core bias current field
// - analog current writes are ignored while protection is enabled
// - protect enable changes only when the key field matches 0x444143
// - protection blocks mode, channel enable, disable and analog current writes
// - a blocked write captures the low byte of its register address in the status field
// - a blocked write sets the violation flag, bit 0 of protect status
`timescale 1ns/1ns
module dac_ctrl_regs
  import dac_pkg::*;
(
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  // register port
  input  wire logic [31:0]          ADDR,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic      [31:0]          RDATA,
  // converter core
  input  wire logic                 CORE_READY,
  input  wire logic                 CONV_DONE,
  output logic                      SAMPLE_VALID,
  output logic      [DAC_SMP_W-1:0] SAMPLE_DATA,
  output logic                      SAMPLE_CHAN,
  output logic      [1:0]           CHAN_ENABLE,
  output logic      [3:0]           OUTPUT_CURRENT,
  output logic      [1:0]           CORE_BIAS,
  // interrupt request
  output logic                      IRQ
);

  // address match, shared by the write and read decoders
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // -------- state
  logic                 word_q;
  logic [1:0]           user_sel_q;
  logic [1:0]           chen_q;
  logic [DAC_NIRQ-1:0]  imask_q;
  logic                 eoc_q;
  logic                 transfer_end_flag_q;
  logic                 bufe_q;
  logic [1:0]           out_cur0_q;
  logic [1:0]           out_cur1_q;
  logic [1:0]           core_bias_q;
  logic                 protect_enable_q;
  logic                 violation_flag_q;
  logic [7:0]           violation_address_q;
  logic [DAC_CNT_W-1:0] tcnt_q;
  logic [DAC_CNT_W-1:0] tncnt_q;
  logic [31:0]          rdata_q;
  logic                 irq_q;

  // -------- sequencer link
  // the sequencer holds at most one data word; its ready output is the
  // transmit ready flag, so a second word waits for software or the
  // transfer engine to see the flag come back
  dac_seq_if sif ();

  dac_seq u_seq (
    .clk  (CLK),
    .srst (SRST),
    .sif  (sif.seq)
  );

  // -------- write decode
  logic wr_mode;
  logic wr_chen;
  logic wr_chdis;
  logic wr_data;
  logic wr_ien;
  logic wr_idis;
  logic wr_acur;
  logic wr_wpmode;
  logic wr_tcnt;
  logic wr_tncnt;
  logic wr_guarded;
  logic wr_blocked;
  logic wr_allowed;
  logic key_ok;

  assign wr_mode   = WR && hit(ADDR, DAC_MODE_ADDR);
  assign wr_chen   = WR && hit(ADDR, DAC_CHEN_ADDR);
  assign wr_chdis  = WR && hit(ADDR, DAC_CHDIS_ADDR);
  assign wr_data   = WR && hit(ADDR, DAC_DATA_ADDR);
  assign wr_ien    = WR && hit(ADDR, DAC_IEN_ADDR);
  assign wr_idis   = WR && hit(ADDR, DAC_IDIS_ADDR);
  assign wr_acur   = WR && hit(ADDR, DAC_ACUR_ADDR);
  assign wr_wpmode = WR && hit(ADDR, DAC_WPMODE_ADDR);
  assign wr_tcnt   = WR && hit(ADDR, DAC_TCNT_ADDR);
  assign wr_tncnt  = WR && hit(ADDR, DAC_TNCNT_ADDR);

  // the four guarded registers share one protection gate
  assign wr_guarded = wr_mode || wr_chen || wr_chdis || wr_acur;
  assign wr_blocked = wr_guarded && protect_enable_q;
  assign wr_allowed = !protect_enable_q;
  assign key_ok     = (WDATA[31:DAC_WP_KEY_LSB] == DAC_WP_KEY);

  // -------- read decode
  logic rd_istat;
  logic rd_wpstat;

  assign rd_istat  = RD && hit(ADDR, DAC_ISTAT_ADDR);
  assign rd_wpstat = RD && hit(ADDR, DAC_WPSTAT_ADDR);

  // -------- sample hand-off
  // a data word offered while the sequencer is busy is dropped; the
  // ready flag tells software (or the transfer engine) when to write
  logic data_take;

  assign data_take      = wr_data && sif.ready;
  assign sif.push       = data_take;
  assign sif.wdata      = word_q ? WDATA : {16'h0000, WDATA[15:0]};
  assign sif.word       = word_q;
  assign sif.chan       = user_sel_q[0];
  assign sif.core_ready = CORE_READY;

  // -------- transfer counter
  // each accepted data word counts down the current counter; on reaching
  // zero the next counter, if loaded, moves up in its place
  // a zero counter is idle: data words then pass without counting
  logic                 cnt_step;
  logic                 cnt_hits_zero;
  logic [DAC_CNT_W-1:0] tcnt_dec;

  assign cnt_step      = data_take && (tcnt_q != DAC_CNT_RST);
  assign tcnt_dec      = tcnt_q - 16'h0001;
  assign cnt_hits_zero = cnt_step && (tcnt_dec == DAC_CNT_RST);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      tcnt_q  <= DAC_CNT_RST;
      tncnt_q <= DAC_CNT_RST;
    end else if (wr_tcnt || wr_tncnt) begin
      if (wr_tcnt) begin
        tcnt_q <= WDATA[DAC_CNT_W-1:0];
      end
      if (wr_tncnt) begin
        tncnt_q <= WDATA[DAC_CNT_W-1:0];
      end
    end else if (cnt_hits_zero) begin
      tcnt_q  <= tncnt_q;
      tncnt_q <= DAC_CNT_RST;
    end else if (cnt_step) begin
      tcnt_q <= tcnt_dec;
    end
  end

  // -------- mode and channel state
  // neither the mode nor the channel state moves while protection is on
  always_ff @(posedge CLK) begin
    if (SRST) begin
      word_q     <= 1'b0;
      user_sel_q <= 2'h0;
      chen_q     <= DAC_CHEN_RST;
    end else begin
      if (wr_mode && wr_allowed) begin
        word_q     <= WDATA[DAC_MODE_WORD_BIT];
        user_sel_q <= WDATA[DAC_MODE_SEL_LSB +: 2];
      end
      if (wr_chen && wr_allowed) begin
        chen_q <= chen_q | WDATA[1:0];
      end else if (wr_chdis && wr_allowed) begin
        chen_q <= chen_q & ~WDATA[1:0];
      end
    end
  end

  // -------- analog current control
  always_ff @(posedge CLK) begin
    if (SRST) begin
      out_cur0_q  <= DAC_OUTCUR_RST[1:0];
      out_cur1_q  <= DAC_OUTCUR_RST[3:2];
      core_bias_q <= DAC_BIAS_RST;
    end else if (wr_acur && wr_allowed) begin
      out_cur0_q  <= WDATA[1:0];
      out_cur1_q  <= WDATA[3:2];
      core_bias_q <= WDATA[DAC_ACUR_CORE_LSB +: 2];
    end
  end

  // -------- interrupt mask, one bit per source
  // enable and disable never arrive together, so the order here is moot
  genvar gi;
  generate
    for (gi = 0; gi < DAC_NIRQ; gi++) begin : g_mask
      always_ff @(posedge CLK) begin
        if (SRST) begin
          imask_q[gi] <= DAC_IMASK_RST[gi];
        end else if (wr_ien && WDATA[gi]) begin
          imask_q[gi] <= 1'b1;
        end else if (wr_idis && WDATA[gi]) begin
          imask_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // -------- status flags
  // a new event in the cycle of its clear wins, so no event is lost
  always_ff @(posedge CLK) begin
    if (SRST) begin
      eoc_q   <= 1'b0;
      transfer_end_flag_q <= 1'b0;
      bufe_q  <= 1'b0;
    end else begin
      if (CONV_DONE) begin
        eoc_q <= 1'b1;
      end else if (rd_istat) begin
        eoc_q <= 1'b0;
      end
      if (cnt_hits_zero) begin
        transfer_end_flag_q <= 1'b1;
        bufe_q  <= 1'b1;
      end else if (wr_tcnt || wr_tncnt) begin
        transfer_end_flag_q <= 1'b0;
        bufe_q  <= 1'b0;
      end
    end
  end

  // -------- write protection
  // a blocked write in the same cycle as a status read is kept, since the
  // read returned the older state and software has not yet seen this one
  always_ff @(posedge CLK) begin
    if (SRST) begin
      protect_enable_q    <= 1'b0;
      violation_flag_q    <= 1'b0;
      violation_address_q <= 8'h00;
    end else begin
      if (wr_wpmode && key_ok) begin
        protect_enable_q <= WDATA[0];
      end
      if (wr_blocked) begin
        violation_flag_q    <= 1'b1;
        violation_address_q <= ADDR[7:0];
      end else if (rd_wpstat) begin
        violation_flag_q    <= 1'b0;
        violation_address_q <= 8'h00;
      end
    end
  end

  // -------- read data
  // status words assembled from live state; unmapped and write-only
  // addresses read as zero
  logic [DAC_NIRQ-1:0] istat;
  logic [31:0]         mode_word;
  logic [31:0]         chstat_word;
  logic [31:0]         imask_word;
  logic [31:0]         istat_word;
  logic [31:0]         acur_word;
  logic [31:0]         wpmode_word;
  logic [31:0]         wpstat_word;
  logic [31:0]         rd_mux;

  assign istat[DAC_IRQ_TRANSMIT_READY_FLAG]  = sif.ready;
  assign istat[DAC_IRQ_EOC]    = eoc_q;
  assign istat[DAC_IRQ_TRANSFER_END_FLAG]  = transfer_end_flag_q;
  assign istat[DAC_IRQ_BUFFER_EMPTY_FLAG] = bufe_q;

  assign mode_word   = {14'h0000, user_sel_q, 11'h000, word_q, 4'h0};
  assign chstat_word = {30'h00000000, chen_q};
  assign imask_word  = {28'h0000000, imask_q};
  assign istat_word  = {28'h0000000, istat};
  assign acur_word   = {22'h000000, core_bias_q, 4'h0, out_cur1_q, out_cur0_q};
  assign wpmode_word = {31'h00000000, protect_enable_q};
  assign wpstat_word = {16'h0000, violation_address_q, 7'h00, violation_flag_q};

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(ADDR, DAC_MODE_ADDR)) begin
      rd_mux = mode_word;
    end else if (hit(ADDR, DAC_CHSTAT_ADDR)) begin
      rd_mux = chstat_word;
    end else if (hit(ADDR, DAC_IMASK_ADDR)) begin
      rd_mux = imask_word;
    end else if (hit(ADDR, DAC_ISTAT_ADDR)) begin
      rd_mux = istat_word;
    end else if (hit(ADDR, DAC_ACUR_ADDR)) begin
      rd_mux = acur_word;
    end else if (hit(ADDR, DAC_WPMODE_ADDR)) begin
      rd_mux = wpmode_word;
    end else if (hit(ADDR, DAC_WPSTAT_ADDR)) begin
      rd_mux = wpstat_word;
    end else if (hit(ADDR, DAC_TCNT_ADDR)) begin
      rd_mux = {16'h0000, tcnt_q};
    end else if (hit(ADDR, DAC_TNCNT_ADDR)) begin
      rd_mux = {16'h0000, tncnt_q};
    end
  end

  // read data stands only in the cycle after the strobe
  // and is zero otherwise, so a stale word is never taken for an answer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= RD ? rd_mux : 32'h00000000;
    end
  end

  // -------- interrupt request, registered so the pin never glitches
  // the request lags its flags and mask by one cycle; nothing is latched,
  // so a flag cleared before the next edge leaves no request behind
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat & imask_q);
    end
  end

  // -------- outputs
  assign RDATA          = rdata_q;
  assign IRQ            = irq_q;
  assign SAMPLE_VALID   = sif.smp_valid;
  assign SAMPLE_DATA    = sif.smp_data;
  assign SAMPLE_CHAN    = sif.smp_chan;
  assign CHAN_ENABLE    = chen_q;
  assign OUTPUT_CURRENT = {out_cur1_q, out_cur0_q};
  assign CORE_BIAS      = core_bias_q;

endmodule // dac_ctrl_regs

// [dv/dac_ctrl_regs_props.sv]
// dac_ctrl_regs_props: port-level checks on the converter controller.
// assumes one clock CLK and the synchronous active-high reset SRST.
`timescale 1ns/1ns
module dac_ctrl_regs_props
  import dac_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // register port
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // converter side
  input wire logic        CORE_READY,
  input wire logic        SAMPLE_VALID,
  input wire logic [1:0]  CHAN_ENABLE,
  input wire logic [3:0]  OUTPUT_CURRENT,
  input wire logic [1:0]  CORE_BIAS,
  input wire logic        IRQ
);
  logic       prot_q;
  logic       viol_q;
  logic [7:0] vaddr_q;

  // decode of the protection-related accesses
  wire logic key_ok  = WR && ADDR == DAC_WPMODE_ADDR && WDATA[31:8] == DAC_WP_KEY;
  wire logic guarded = WR && (ADDR == DAC_MODE_ADDR || ADDR == DAC_CHEN_ADDR
                       || ADDR == DAC_CHDIS_ADDR || ADDR == DAC_ACUR_ADDR);
  wire logic blocked = guarded && prot_q;
  wire logic acur_wr = WR && ADDR == DAC_ACUR_ADDR;
  wire logic wps_rd  = RD && ADDR == DAC_WPSTAT_ADDR;

  // shadow of the protection state; a blocked write beats a clearing read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prot_q  <= 1'b0;
      viol_q  <= 1'b0;
      vaddr_q <= 8'h00;
    end else begin
      if (key_ok) prot_q <= WDATA[0];
      if (blocked) begin
        viol_q  <= 1'b1;
        vaddr_q <= ADDR[7:0];
      end else if (wps_rd) begin
        viol_q  <= 1'b0;
        vaddr_q <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  a_chan_status: assert property (
    RD && ADDR == DAC_CHSTAT_ADDR |=> RDATA == {30'h0, $past(CHAN_ENABLE)})
    else $error("channel status read differs from enable pins");
  a_sample_ready: assert property (
    SAMPLE_VALID |-> $past(CORE_READY))
    else $error("sample sent without core ready");
  a_wo_reads_zero: assert property (
    RD && (ADDR == DAC_DATA_ADDR || ADDR == DAC_IEN_ADDR || ADDR == DAC_IDIS_ADDR)
    |=> RDATA == 32'h0)
    else $error("write-only register read nonzero");
  a_irq_disable: assert property (
    WR && ADDR == DAC_IDIS_ADDR && WDATA[3:0] == 4'hf |=> ##1 !IRQ)
    else $error("interrupt still raised after full disable");
  a_acur_apply: assert property (
    acur_wr && !prot_q |=> OUTPUT_CURRENT == $past(WDATA[3:0])
    && CORE_BIAS == $past(WDATA[9:8]))
    else $error("current control not applied");
  a_acur_hold: assert property (
    acur_wr && prot_q |=> $stable(OUTPUT_CURRENT) && $stable(CORE_BIAS))
    else $error("protected current control changed");
  a_chan_hold: assert property (
    WR && (ADDR == DAC_CHEN_ADDR || ADDR == DAC_CHDIS_ADDR) && prot_q
    |=> $stable(CHAN_ENABLE))
    else $error("protected channel state changed");
  a_key_readback: assert property (
    RD && ADDR == DAC_WPMODE_ADDR |=> RDATA == {31'h0, $past(prot_q)})
    else $error("protect enable not keyed");
  a_viol_report: assert property (
    wps_rd |=> RDATA == {16'h0, $past(vaddr_q), 7'h0, $past(viol_q)})
    else $error("violation status wrong");

  c_word_pair: cover property (SAMPLE_VALID ##1 SAMPLE_VALID);
  c_blocked: cover property (blocked);
  c_irq_rise: cover property ($rose(IRQ));
endmodule // dac_ctrl_regs_props

bind dac_ctrl_regs dac_ctrl_regs_props dac_ctrl_regs_props_inst (
  .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CORE_READY(CORE_READY), .SAMPLE_VALID(SAMPLE_VALID),
  .CHAN_ENABLE(CHAN_ENABLE), .OUTPUT_CURRENT(OUTPUT_CURRENT),
  .CORE_BIAS(CORE_BIAS), .IRQ(IRQ));

// [dv/dac_core_model.sv]
// dac_core_model: behavioural converter core; takes samples, reports each
// finished conversion one cycle later and logs every sample taken.
// assumes the bench steers stalls through stall_req.
`timescale 1ns/1ns
module dac_core_model
  import dac_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // stall request from the bench
  input  wire logic                 stall_req,
  // sample link
  input  wire logic                 sample_valid,
  input  wire logic [DAC_SMP_W-1:0] sample_data,
  input  wire logic                 sample_chan,
  output logic                      core_ready,
  output logic                      conv_done
);
  logic [16:0] got [$];

  // ready lags the stall request a cycle, as a busy core would
  always @(posedge clk) begin
    if (srst) begin
      core_ready <= 1'b0;
      conv_done  <= 1'b0;
    end else begin
      core_ready <= !stall_req;
      conv_done  <= sample_valid;
      if (sample_valid) got.push_back({sample_chan, sample_data});
    end
  end
endmodule // dac_core_model

// [dv/dac_ctrl_regs_bench.sv]
// dac_ctrl_regs_bench: self-checking bench for the controller registers.
// assumes a 50 MHz clock and the bench as the only register master.
`timescale 1ns/1ns
module dac_ctrl_regs_bench;
  import dac_pkg::*;
  logic                 clk, srst, wr, rd, stall, core_ready, conv_done;
  logic                 s_valid, s_chan, irq;
  logic [31:0]          addr, wdata, rdata;
  logic [DAC_SMP_W-1:0] s_data;
  logic [1:0]           chan_en, bias;
  logic [3:0]           out_cur;
  int                   error_cnt, compares;

  dac_ctrl_regs dac_ctrl_regs_inst (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CORE_READY(core_ready), .CONV_DONE(conv_done),
    .SAMPLE_VALID(s_valid), .SAMPLE_DATA(s_data), .SAMPLE_CHAN(s_chan),
    .CHAN_ENABLE(chan_en), .OUTPUT_CURRENT(out_cur), .CORE_BIAS(bias), .IRQ(irq));
  dac_core_model dac_core_model_inst (.clk(clk), .srst(srst), .stall_req(stall),
    .sample_valid(s_valid), .sample_data(s_data), .sample_chan(s_chan),
    .core_ready(core_ready), .conv_done(conv_done));

  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // one-cycle write strobe, then a quiet cycle so strobes never retoggle at once
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
    chk(d, exp, what);
  endtask

  function automatic logic [31:0] smp(input int i);
    return {15'h0, dac_core_model_inst.got[i]};
  endfunction

  // bounded wait for the core to log n samples, then let the flags settle
  task automatic wait_smp(input int n);
    for (int i = 0; i < 20 && dac_core_model_inst.got.size() < n; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(dac_core_model_inst.got.size(), n, "sample count");
  endtask

  task automatic t_reset;
    rd_chk(DAC_CHSTAT_ADDR, 32'h0, "chan status");
    rd_chk(DAC_IMASK_ADDR, 32'h0, "mask");
    rd_chk(DAC_ISTAT_ADDR, 32'h1, "status");
    rd_chk(DAC_IEN_ADDR, 32'h0, "write-only");
    rd_chk(32'h4003c0f0, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_irq;
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < DAC_NIRQ; i++) begin
      wr_reg(DAC_IEN_ADDR, 32'h1 << i);
      m = m | (32'h1 << i);
      rd_chk(DAC_IMASK_ADDR, m, "mask set");
    end
    #1;
    chk({31'h0, irq}, 32'h1, "irq on ready");
    wr_reg(DAC_IDIS_ADDR, 32'h0);
    rd_chk(DAC_IMASK_ADDR, 32'hf, "zero write");
    for (int i = 0; i < DAC_NIRQ; i++) begin
      wr_reg(DAC_IDIS_ADDR, 32'h1 << i);
      m = m & ~(32'h1 << i);
      rd_chk(DAC_IMASK_ADDR, m, "mask clear");
    end
    #1;
    chk({31'h0, irq}, 32'h0, "irq off");
    $display("test irq done");
  endtask

  // channel enable sets bits, channel disable clears them; status and enable pins follow
  task automatic t_chan;
    wr_reg(DAC_CHEN_ADDR, 32'h3);
    rd_chk(DAC_CHSTAT_ADDR, 32'h3, "both on");
    wr_reg(DAC_CHDIS_ADDR, 32'h1);
    rd_chk(DAC_CHSTAT_ADDR, 32'h2, "ch0 off");
    #1;
    chk({30'h0, chan_en}, 32'h2, "enable pins");
    $display("test channels done");
  endtask

  task automatic t_data;
    wr_reg(DAC_MODE_ADDR, 32'h0001_0000);
    wr_reg(DAC_DATA_ADDR, 32'hbeef_1234);
    wait_smp(1);
    chk(smp(0), 32'h0001_1234, "half sample");
    rd_chk(DAC_ISTAT_ADDR, 32'h3, "eoc set");
    rd_chk(DAC_ISTAT_ADDR, 32'h1, "eoc cleared");
    wr_reg(DAC_MODE_ADDR, 32'h0000_0010);
    wr_reg(DAC_DATA_ADDR, 32'h5a5a_0f0f);
    wait_smp(3);
    chk(smp(1), 32'h0000_0f0f, "low half");
    chk(smp(2), 32'h0000_5a5a, "high half");
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    wr_reg(DAC_DATA_ADDR, 32'h2222_1111);
    rd_chk(DAC_ISTAT_ADDR, 32'h2, "busy");
    wr_reg(DAC_DATA_ADDR, 32'h4444_3333);
    stall <= 1'b0;
    wait_smp(5);
    chk(smp(3), 32'h0000_1111, "stalled low");
    chk(smp(4), 32'h0000_2222, "stalled high");
    $display("test data done");
  endtask

  task automatic t_count;
    wr_reg(DAC_TNCNT_ADDR, 32'h0);
    wr_reg(DAC_TCNT_ADDR, 32'h2);
    wr_reg(DAC_IEN_ADDR, 32'h4);
    wr_reg(DAC_DATA_ADDR, 32'h0);
    wait_smp(7);
    rd_chk(DAC_ISTAT_ADDR, 32'h3, "one step");
    wr_reg(DAC_DATA_ADDR, 32'h0);
    wait_smp(9);
    rd_chk(DAC_ISTAT_ADDR, 32'hf, "count zero");
    #1;
    chk({31'h0, irq}, 32'h1, "irq transfer");
    rd_chk(DAC_ISTAT_ADDR, 32'hd, "flags stay");
    wr_reg(DAC_TNCNT_ADDR, 32'h0);
    rd_chk(DAC_ISTAT_ADDR, 32'h1, "write clears");
    wr_reg(DAC_IDIS_ADDR, 32'hf);
    $display("test counter done");
  endtask

  task automatic t_prot;
    logic [31:0] pa [4] = '{DAC_MODE_ADDR, DAC_CHEN_ADDR, DAC_CHDIS_ADDR, DAC_ACUR_ADDR};
    logic [31:0] pd [4] = '{32'h0, 32'h1, 32'h2, 32'h0};
    wr_reg(DAC_ACUR_ADDR, 32'h0000_0206);
    rd_chk(DAC_ACUR_ADDR, 32'h206, "current");
    #1;
    chk({26'h0, bias, out_cur}, 32'h26, "current pins");
    wr_reg(DAC_WPMODE_ADDR, 32'h1234_5601);
    rd_chk(DAC_WPMODE_ADDR, 32'h0, "wrong key");
    wr_reg(DAC_WPMODE_ADDR, {DAC_WP_KEY, 8'h01});
    rd_chk(DAC_WPMODE_ADDR, 32'h1, "locked");
    for (int i = 0; i < 4; i++) begin
      wr_reg(pa[i], pd[i]);
      rd_chk(DAC_WPSTAT_ADDR, {16'h0, pa[i][7:0], 8'h01}, "violation");
      rd_chk(DAC_WPSTAT_ADDR, 32'h0, "status cleared");
    end
    rd_chk(DAC_CHSTAT_ADDR, 32'h2, "chan kept");
    rd_chk(DAC_ACUR_ADDR, 32'h206, "current kept");
    wr_reg(DAC_WPMODE_ADDR, {DAC_WP_KEY, 8'h00});
    wr_reg(DAC_ACUR_ADDR, 32'h0000_0105);
    rd_chk(DAC_ACUR_ADDR, 32'h105, "unlocked");
    $display("test protect done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence: reset for 8 cycles, then the scenarios
  initial begin
    error_cnt = 0;
    compares  = 0;
    srst      = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    stall     = 1'b0;
    addr      = 32'h0;
    wdata     = 32'h0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_irq;
    t_chan;
    t_data;
    t_count;
    t_prot;
    tally_and_finish;
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule // dac_ctrl_regs_bench
